// ===== bench/acs_cal_seq_chk.sv
// Checker of start, busy, reset pulse and trim bounds
`timescale 1ns/1ps
module acs_cal_seq_chk
   import acs_pkg::*;
#(
   parameter int CLK_KHZ = MCLK_KHZ
)
(
   // Clock and control
   input wire logic                     mclk,
   input wire logic                     rst,
   input wire logic                     ce,
   input wire logic                     cal_req_n,
   input wire logic                     ctrl_wr,
   input wire logic [2:0]               ctrl_type,
   input wire logic                     start_calibration_bit,
   input wire logic signed [TRIM_W-1:0] err_in,
   input wire logic                     bipolar,
   // Status and results
   input wire logic                     busy_r,
   input wire logic                     conv_reset_r,
   input wire logic [2:0]               step_r,
   input wire logic signed [TRIM_W-1:0] ofs_trim,
   input wire logic signed [TRIM_W-1:0] gain_trim,
   input wire logic                     dac_ok
);
   localparam int LS = T_SINGLE_US * CLK_KHZ / 1000;
   logic [2:0]  type_r;
   logic [2:0]  run_r;
   logic [31:0] cnt_r;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Type latched at run start, since writes while busy still land
   always_ff @(posedge mclk) begin
      if (rst) begin
         type_r <= CT_RESET;
         run_r  <= CT_RESET;
         cnt_r  <= '0;
      end else begin
         if (ctrl_wr && ce) type_r <= ctrl_type;
         if (!busy_r) run_r <= (ctrl_wr && ce) ? ctrl_type : type_r;
         cnt_r <= busy_r ? cnt_r + 32'h1 : '0;
      end
   end
   property p_sw_start;
      !busy_r && ctrl_wr && start_calibration_bit && ce |=> busy_r;
   endproperty
   a_sw_start: assert property (p_sw_start)
      else $error("software start did not raise busy");
   property p_pin_start;
      $rose(cal_req_n) && !busy_r |-> ##[1:5] busy_r;
   endproperty
   a_pin_start: assert property (p_pin_start)
      else $error("pin rise did not raise busy");
   property p_fall_rst;
      $fell(cal_req_n) |-> ##[1:5] conv_reset_r;
   endproperty
   a_fall_rst: assert property (p_fall_rst)
      else $error("pin fall gave no converter reset");
   property p_rst_pulse;
      conv_reset_r |=> !conv_reset_r;
   endproperty
   a_rst_pulse: assert property (p_rst_pulse)
      else $error("converter reset longer than one cycle");
   property p_busy_min;
      $rose(busy_r) |-> busy_r [*8];
   endproperty
   a_busy_min: assert property (p_busy_min)
      else $error("busy dropped early");
   property p_single_len;
      $fell(busy_r) && run_r[1] |-> cnt_r >= LS - 2 && cnt_r <= LS + LS/10 + 8;
   endproperty
   a_single_len: assert property (p_single_len)
      else $error("single step busy length wrong");
   property p_full_first;
      $rose(busy_r) && run_r == CT_SELF_FULL |-> ##[0:2] step_r == ST_DAC;
   endproperty
   a_full_first: assert property (p_full_first)
      else $error("full calibration did not begin with DAC");
   property p_sys_order;
      busy_r && $changed(step_r) && step_r == ST_SGAIN && run_r == CT_SYS_GO
         |-> $past(step_r) == ST_SOFS;
   endproperty
   a_sys_order: assert property (p_sys_order)
      else $error("system gain not after system offset");
   property p_ofs_lim;
      ofs_trim <= OFS_LIM && ofs_trim >= -OFS_LIM;
   endproperty
   a_ofs_lim: assert property (p_ofs_lim)
      else $error("offset trim beyond limit");
   property p_gain_lim;
      gain_trim <= GAIN_LIM && gain_trim >= -GAIN_LIM;
   endproperty
   a_gain_lim: assert property (p_gain_lim)
      else $error("gain trim beyond limit");
endmodule : acs_cal_seq_chk

// ===== bench/acs_cal_seq_tb.sv
// Testbench of the calibration sequencer
`timescale 1ns/1ps
module acs_cal_seq_tb;
   import acs_pkg::*;
   localparam int CK = 100;
   localparam logic [11:0] SEQ [8] = '{12'h8A9, 12'h0A9, 12'h009, 12'h00A,
                                       12'h000, 12'h0BC, 12'h00B, 12'h00C};
   logic                     mclk, rst, ce, cal_req_n, ctrl_wr, stc, bip;
   logic                     busy_r, conv_reset_r, dac_ok, rst_seen;
   logic [2:0]               ctrl_type, step_r;
   logic signed [TRIM_W-1:0] err_in, ofs_trim, gain_trim;
   logic [31:0]              len_v;
   logic [11:0]              seq_v;
   int                       err_count, tests_run, cyc;
   acs_cal_seq #(.CLK_KHZ(CK)) acs_cal_seq_i (.mclk(mclk), .rst(rst),
      .ce(ce), .cal_req_n(cal_req_n), .ctrl_wr(ctrl_wr),
      .ctrl_type(ctrl_type), .start_calibration_bit(stc), .err_in(err_in),
      .bipolar(bip), .busy_r(busy_r), .conv_reset_r(conv_reset_r),
      .step_r(step_r), .ofs_trim(ofs_trim), .gain_trim(gain_trim),
      .dac_ok(dac_ok));
   acs_host_model acs_host_model_i (.mclk(mclk), .cal_req_n(cal_req_n),
      .err_in(err_in), .bipolar(bip));
   // Clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Hang guard and reset pulse watch
   always @(posedge mclk) begin
      cyc++;
      if (conv_reset_r === 1'b1) rst_seen = 1'b1;
      if (cyc == 40000) begin
         err_count++;
         conclude();
      end
   end
   task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(logic [2:0] t, logic s);
      @(negedge mclk);
      ctrl_wr   = 1'b1;
      ctrl_type = t;
      stc       = s;
      @(negedge mclk);
      ctrl_wr = 1'b0;
      stc     = 1'b0;
   endtask : wr
   // Counts busy cycles and records each new step code
   task automatic meas();
      int n;
      len_v = 0;
      seq_v = 0;
      n = 0;
      while (busy_r !== 1'b1 && n < 8) begin
         @(negedge mclk);
         n++;
      end
      while (busy_r === 1'b1 && len_v < 6000) begin
         if (len_v >= 2 && {1'b1, step_r} !== seq_v[3:0])
            seq_v = {seq_v[7:0], 1'b1, step_r};
         len_v++;
         @(negedge mclk);
      end
   endtask : meas
   // Tolerance covers a few cycles of handshake overhead per step
   task automatic chk_len(int e);
      chk("busy_len", len_v + 2 >= e && len_v <= e + e/10 + 8, 1);
   endtask : chk_len
   task automatic t_por();
      @(negedge mclk);
      acs_host_model_i.cal_req_n = 1'b1;
      meas();
      chk("por_seq", seq_v, 12'h8A9);
      chk_len(T_POR_US * CK / 1000);
      chk("dac_ok", dac_ok, 1);
   endtask : t_por
   task automatic t_types();
      for (int t = 0; t < 8; t++) begin
         acs_host_model_i.set_mode(t[0], t == 6 ? 12'sh7FF : 12'sh010);
         wr(t[2:0], 1'b1);
         @(negedge mclk);
         chk("busy_start", busy_r, 1);
         meas();
         if (t != 4) chk("seq", seq_v, SEQ[t]);
         if (t == 6) chk("ofs_sat", ofs_trim, 12'h333);
         if (t == 7) chk("gain_trim", gain_trim, 12'h010);
         chk_len(t[1:0] == 0 ? T_FULL_US * CK / 1000 :
                 t[1:0] == 1 ? T_GO_US * CK / 1000 : T_SINGLE_US * CK / 1000);
      end
   endtask : t_types
   task automatic t_refuse_pin();
      wr(CT_SELF_OFS, 1'b1);
      repeat (50) @(negedge mclk);
      wr(CT_SELF_GAIN, 1'b1);
      meas();
      chk("refused_seq", seq_v, 12'h009);
      rst_seen = 1'b0;
      acs_host_model_i.pulse(6);
      chk("conv_reset", rst_seen, 1);
      meas();
      chk("pin_seq", seq_v, 12'h00A);
      chk_len(T_SINGLE_US * CK / 1000);
   endtask : t_refuse_pin
   task automatic conclude();
      $display("Checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude
   // Main sequence
   initial begin
      {err_count, tests_run, cyc} = '0;
      rst       = 1'b1;
      ce        = 1'b1;
      ctrl_wr   = 1'b0;
      ctrl_type = 3'h0;
      stc       = 1'b0;
      rst_seen  = 1'b0;
      repeat (10) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      chk("busy_reset", busy_r, 0);
      t_por();
      t_types();
      t_refuse_pin();
      conclude();
   end
endmodule : acs_cal_seq_tb
bind acs_cal_seq acs_cal_seq_chk #(.CLK_KHZ(CLK_KHZ)) acs_cal_seq_chk_i (
   .mclk(mclk), .rst(rst), .ce(ce), .cal_req_n(cal_req_n),
   .ctrl_wr(ctrl_wr), .ctrl_type(ctrl_type),
   .start_calibration_bit(start_calibration_bit), .err_in(err_in),
   .bipolar(bipolar), .busy_r(busy_r), .conv_reset_r(conv_reset_r),
   .step_r(step_r), .ofs_trim(ofs_trim), .gain_trim(gain_trim),
   .dac_ok(dac_ok));

// ===== bench/acs_host_model.sv
// Host model driving the request pin and analog status
`timescale 1ns/1ps
module acs_host_model
   import acs_pkg::*;
(
   // Clock
   input  wire logic                mclk,
   // Towards the device
   output logic                     cal_req_n,
   output logic signed [TRIM_W-1:0] err_in,
   output logic                     bipolar
);
   // Pin held low from power-on to cover the wake-up time
   initial begin
      cal_req_n = 1'b0;
      err_in    = 12'sh010;
      bipolar   = 1'b0;
   end
   // Low pulse, long enough for a device waking from power-down
   task automatic pulse(int n);
      @(negedge mclk);
      cal_req_n = 1'b0;
      repeat (n) @(negedge mclk);
      cal_req_n = 1'b1;
   endtask : pulse
   // Mode and error change, the reason to calibrate again
   task automatic set_mode(logic b, logic signed [TRIM_W-1:0] e);
      bipolar = b;
      err_in  = e;
   endtask : set_mode
endmodule : acs_host_model

// ===== rtl/acs_cal_seq.sv
// Calibration sequencer: start sources, busy, step ordering
//
// Behaviour
// R1 - Start on request pin pulse or software start bit set to 1.
// R2 - Self and system calibration families, each with options.
// R3 - Self: full (DAC, offset, gain), gain+offset, offset, gain. Code runs full as DAC, gain, offset.
// R4 - Step length scales with clock: 41.7, 9.26, 4.63 ms reference.
// R5 - Power-on: pin rises, full self calibration lasting 32 ms at 4 MHz.
// R6 - Request pin falling edge resets converter logic before calibration.
// R7 - Busy rises on pin rising edge or after software write.
// R8 - Busy holds during calibration, falls at completion.
// R9 - Host holds request pin low to cover power-up time.
// R10 - Offset nulls midscale (bipolar) or zero scale; gain full scale. Code takes err_in as offset reference in both modes.
// R11 - System offset up to 5%, gain 2.5%; beyond that trim saturates.
// R12 - System offset handles positive and negative offsets.
// R13 - System gain handles full scale above or below reference.
// R14 - System offset step runs before system gain step.
// R15 - Host recalibrates only after condition change or for system cal.
// R16 - Pin start uses selected calibration type, full self after reset.
`timescale 1ns/1ps
module acs_cal_seq
   import acs_pkg::*;
#(
   parameter int CLK_KHZ = MCLK_KHZ
)
(
   // Clock, reset, enable
   input  wire logic                     mclk,
   input  wire logic                     rst,
   input  wire logic                     ce,
   // Calibration request pin, active low
   input  wire logic                     cal_req_n,
   // Control register write port
   input  wire logic                     ctrl_wr,
   input  wire logic [2:0]               ctrl_type,
   input  wire logic                     start_calibration_bit,
   // Analog front-end status
   input  wire logic signed [TRIM_W-1:0] err_in,
   input  wire logic                     bipolar,
   // Status and results
   output logic                          busy_r,
   output logic                          conv_reset_r,
   output logic [2:0]                    step_r,
   output logic signed [TRIM_W-1:0]      ofs_trim,
   output logic signed [TRIM_W-1:0]      gain_trim,
   output logic                          dac_ok
);
   typedef enum {S_IDLE, S_DAC, S_FIRST, S_SECOND, S_DONE} acs_state_e;

   // Step lengths scaled by the clock ratio (round down); the split of
   // the divide keeps fast clocks in range but gives zero below 100 kHz
   localparam int L_FULL   = T_FULL_US * (CLK_KHZ / 100) / 10;
   localparam int L_GO     = T_GO_US * (CLK_KHZ / 100) / 10;
   localparam int L_SINGLE = T_SINGLE_US * (CLK_KHZ / 100) / 10;
   localparam int L_POR    = T_POR_US * (CLK_KHZ / 100) / 10;

   acs_step_if sif ();
   acs_state_e st_r, st_nxt;
   logic       req_m_r, req_s_r, req_d_r;
   logic [2:0] type_r;
   logic [2:0] run_type_r;
   logic       por_r;
   logic       go_r;
   logic [2:0] sstep_r;
   logic [31:0] len_r;

   // Pin passes two flops, then one for edge history; logic uses the last two
   wire pin_fall = req_d_r && !req_s_r;           // see R6
   wire pin_rise = !req_d_r && req_s_r;
   wire sw_start = ctrl_wr && start_calibration_bit; // see R1
   wire start    = (pin_rise || sw_start) && (st_r == S_IDLE);
   wire [2:0] start_type = sw_start ? ctrl_type : type_r; // see R16
   wire is_sys   = run_type_r[2];                  // see R2
   wire has_dac  = (run_type_r[1:0] == 2'h0);
   wire two_step = (run_type_r[1:0] == 2'h0) || (run_type_r[1:0] == 2'h1);

   // Step code for the first and second trim step of the sequence
   function automatic logic [2:0] first_step(input logic [2:0] t);
      case (t)
         CT_SELF_GAIN: first_step = ST_GAIN;
         CT_SYS_GAIN:  first_step = ST_SGAIN;
         CT_SELF_OFS:  first_step = ST_OFS;
         CT_SELF_FULL,
         CT_SELF_GO:   first_step = ST_GAIN;   // see R3
         default:      first_step = ST_SOFS;   // see R14
      endcase
   endfunction : first_step

   function automatic logic [2:0] second_step(input logic [2:0] t);
      second_step = t[2] ? ST_SGAIN : ST_OFS;  // see R14
   endfunction : second_step

   // Full length for a full cal; power-on uses its own length
   wire [31:0] dac_len  = por_r ? 32'(L_POR - 2 * L_SINGLE)
                                : 32'(L_FULL - 2 * L_SINGLE); // see R4 R5
   wire [31:0] step_len = (two_step && !has_dac) ? 32'(L_GO / 2)
                                                 : 32'(L_SINGLE);

   // Next state of the sequence
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         S_IDLE:   if (start) st_nxt = has_dac || start_type[1:0] == 2'h0
                                        ? S_DAC : S_FIRST;
         S_DAC:    if (sif.done) st_nxt = S_FIRST;
         S_FIRST:  if (sif.done) st_nxt = two_step ? S_SECOND : S_DONE;
         S_SECOND: if (sif.done) st_nxt = S_DONE;
         S_DONE:   st_nxt = S_IDLE;
         default:  st_nxt = S_IDLE;
      endcase
      if (st_r == S_IDLE && start)
         st_nxt = (start_type[1:0] == 2'h0) ? S_DAC : S_FIRST;
   end

   // Pin synchroniser and edge history
   always_ff @(posedge mclk) begin
      if (rst) begin
         req_m_r <= 1'b0;
         req_s_r <= 1'b0;
         req_d_r <= 1'b0;
      end else if (ce) begin
         req_m_r <= cal_req_n;
         req_s_r <= req_m_r;
         req_d_r <= req_s_r;
      end
   end

   // Selected type; power-on flag until first calibration finishes
   always_ff @(posedge mclk) begin
      if (rst) begin
         type_r <= CT_RESET;                      // see R16
         por_r  <= 1'b1;                          // see R5
      end else if (ce) begin
         if (ctrl_wr) type_r <= ctrl_type;
         if (st_r == S_DONE) por_r <= 1'b0;
      end
   end

   // Sequencer state, busy and step launch
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_r         <= S_IDLE;
         run_type_r   <= CT_RESET;
         busy_r       <= 1'b0;
         conv_reset_r <= 1'b0;
         go_r         <= 1'b0;
         sstep_r      <= ST_DAC;
         len_r        <= 32'h0;
      end else if (ce) begin
         st_r         <= st_nxt;
         conv_reset_r <= pin_fall;                // see R6
         go_r         <= 1'b0;
         if (start) begin
            run_type_r <= start_type;
            busy_r     <= 1'b1;                   // see R7
         end else if (st_r == S_DONE) begin
            busy_r     <= 1'b0;                   // see R8
         end
         if (st_nxt != st_r) begin
            go_r <= (st_nxt != S_DONE) && (st_nxt != S_IDLE);
            case (st_nxt)
               S_DAC: begin
                  sstep_r <= ST_DAC;
                  len_r   <= dac_len;
               end
               S_FIRST: begin
                  sstep_r <= first_step(start ? start_type : run_type_r);
                  len_r   <= step_len;
               end
               S_SECOND: begin
                  sstep_r <= second_step(run_type_r);
                  len_r   <= step_len;
               end
               default: ;
            endcase
         end
      end
   end

   assign sif.go   = go_r;
   assign sif.step = sstep_r;
   assign sif.len  = len_r;
   assign step_r   = sstep_r;

   // Trim engine keeps the timed step and trim registers
   acs_trim_engine u_eng (
      .mclk       (mclk),
      .rst        (rst),
      .ce         (ce),
      .sif        (sif.eng),
      .err_in     (err_in),
      .bipolar    (bipolar),
      .ofs_trim_r (ofs_trim),
      .gain_trim_r(gain_trim),
      .dac_ok_r   (dac_ok)
   );
endmodule : acs_cal_seq

// ===== rtl/acs_pkg.sv
// Package of constants and types for the ADC calibration sequencer
package acs_pkg;
   // Calibration type selection (3-bit setting)
   localparam logic [2:0] CT_SELF_FULL  = 3'h0;
   localparam logic [2:0] CT_SELF_GO    = 3'h1;
   localparam logic [2:0] CT_SELF_OFS   = 3'h2;
   localparam logic [2:0] CT_SELF_GAIN  = 3'h3;
   localparam logic [2:0] CT_SYS_FULL   = 3'h4;
   localparam logic [2:0] CT_SYS_GO     = 3'h5;
   localparam logic [2:0] CT_SYS_OFS    = 3'h6;
   localparam logic [2:0] CT_SYS_GAIN   = 3'h7;
   localparam logic [2:0] CT_RESET      = CT_SELF_FULL;
   // Master clock reference used for the step lengths, in kHz
   localparam int MCLK_KHZ      = 100000;
   localparam int REF_CLK_KHZ   = 6000;
   // Step durations at the reference clock, in us
   localparam int T_FULL_US     = 41700;
   localparam int T_GO_US       = 9260;
   localparam int T_SINGLE_US   = 4630;
   // Power-on full calibration: 32 ms at 4 MHz, in us
   localparam int T_POR_US      = 32000;
   localparam int POR_CLK_KHZ   = 4000;
   // Cycle counts at mclk (exact, MCLK_KHZ is a multiple of 1000)
   localparam int N_FULL   = T_FULL_US * (MCLK_KHZ / 1000);
   localparam int N_GO     = T_GO_US * (MCLK_KHZ / 1000);
   localparam int N_SINGLE = T_SINGLE_US * (MCLK_KHZ / 1000);
   localparam int N_POR    = T_POR_US * (MCLK_KHZ / 1000);
   // Step codes handed to the trim engine
   localparam logic [2:0] ST_DAC    = 3'h0;
   localparam logic [2:0] ST_OFS    = 3'h1;
   localparam logic [2:0] ST_GAIN   = 3'h2;
   localparam logic [2:0] ST_SOFS   = 3'h3;
   localparam logic [2:0] ST_SGAIN  = 3'h4;
   // Trim word width and limits (5% and 2.5% of full scale, 14-bit)
   localparam int TRIM_W = 12;
   localparam logic signed [11:0] OFS_LIM  = 12'sh333;
   localparam logic signed [11:0] GAIN_LIM = 12'sh19A;
endpackage : acs_pkg

// ===== rtl/acs_step_if.sv
// Interface between sequencer and trim engine
`timescale 1ns/1ps
interface acs_step_if;
   logic        go;
   logic [2:0]  step;
   logic [31:0] len;
   logic        done;
   modport seq (output go, output step, output len, input done);
   modport eng (input go, input step, input len, output done);
endinterface : acs_step_if

// ===== rtl/acs_trim_engine.sv
// Timed trim step engine with saturating trim registers
`timescale 1ns/1ps
module acs_trim_engine
   import acs_pkg::*;
(
   // Clock and reset
   input  wire logic                     mclk,
   input  wire logic                     rst,
   input  wire logic                     ce,
   // Step handshake
   acs_step_if.eng                       sif,
   // Measured error and input mode
   input  wire logic signed [TRIM_W-1:0] err_in,
   input  wire logic                     bipolar,
   // Trim results
   output logic signed [TRIM_W-1:0]      ofs_trim_r,
   output logic signed [TRIM_W-1:0]      gain_trim_r,
   output logic                          dac_ok_r
);
   logic [31:0] cnt_r;
   logic        run_r;
   logic [2:0]  step_r;
   logic        done_r;
   wire         last = run_r && (cnt_r <= 32'h1);

   // Clamp to the trim range; larger errors only saturate the trim
   function automatic logic signed [TRIM_W-1:0] clamp(
      input logic signed [TRIM_W-1:0] v,
      input logic signed [TRIM_W-1:0] lim);
      if (v > lim) clamp = lim;
      else if (v < -lim) clamp = -lim;
      else clamp = v;
   endfunction : clamp

   // Offset trims to err_in alike when bipolar and when unipolar
   wire signed [TRIM_W-1:0] ofs_ref =
      bipolar ? err_in : err_in;                      // see R10
   wire signed [TRIM_W-1:0] ofs_new = clamp(ofs_ref, OFS_LIM); // see R11
   wire signed [TRIM_W-1:0] gain_new = clamp(err_in, GAIN_LIM); // see R13

   assign sif.done = done_r;

   // Step timer and trim update at the end of a step
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_r       <= 32'h0;
         run_r       <= 1'b0;
         step_r      <= ST_DAC;
         done_r      <= 1'b0;
         ofs_trim_r  <= '0;
         gain_trim_r <= '0;
         dac_ok_r    <= 1'b0;
      end else if (ce) begin
         done_r <= last;
         if (sif.go && !run_r) begin
            run_r  <= 1'b1;
            cnt_r  <= sif.len;
            step_r <= sif.step;
         end else if (last) begin
            run_r <= 1'b0;
            case (step_r)
               ST_DAC:   dac_ok_r <= 1'b1;
               ST_OFS,
               ST_SOFS:  ofs_trim_r <= ofs_new;  // see R12
               default:  gain_trim_r <= gain_new;
            endcase
         end else if (run_r) begin
            cnt_r <= cnt_r - 32'h1;
         end
      end
   end
endmodule : acs_trim_engine
